// ### shared/vfc_defines.svh
// Purpose: constants of the video filter control register block
// Assumes: 250 MHz system clock
// Notes:   times in ns, cycle counts derived in the top module
`ifndef VFC_DEFINES_SVH
`define VFC_DEFINES_SVH
`define VFC_CLK_NS        4
`define VFC_T0_MIN_NS     1000
`define VFC_T0_MAX_NS     8000
`define VFC_T1_MIN_NS     24000
`define VFC_T1_MAX_NS     36000
`define VFC_TT_MIN_NS     80000
`define VFC_TT_MAX_NS     120000
`define VFC_READ_LOW_NS   6000
`define VFC_TRIM_NS       1000
`define VFC_ADDR_STEP_NS  10000000
`define VFC_CTRL_RESET    8'h60
`define VFC_CMD_WRITE     2'h0
`define VFC_CMD_READ      2'h1
`define VFC_CMD_BCAST     2'h2
`define VFC_ADDR_MAX      4'hf
`define VFC_TRIM_MID      6'h20
`define VFC_TRIM_TOP      6'h3f
`define VFC_LOW_SAT       15'h7fff
`endif

// ### shared/vfc_pkg.sv
// Purpose: types of the video filter control register block
// Assumes: constants live in vfc_defines.svh
// Notes:   field order is MSB first, first bit on the wire is the LSB
package vfc_pkg;
	typedef struct packed {
		logic sync_pin_dir;
		logic input_select;
		logic filter_in_path;
		logic clamp_level_sel;
		logic hf_gain_hi;
		logic hf_gain_lo;
		logic output_mute;
		logic rsvd;
	} vfc_ctrl_t;

	typedef enum logic [2:0] {
		PK_NONE  = 3'h0,
		PK_ZERO  = 3'h1,
		PK_ONE   = 3'h2,
		PK_TRANS = 3'h3,
		PK_BAD   = 3'h4
	} vfc_pulse_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD  = 3'h1,
		ST_ADDR = 3'h2,
		ST_DATA = 3'h3,
		ST_END  = 3'h4,
		ST_READ = 3'h5,
		ST_RDRV = 3'h6,
		ST_RGAP = 3'h7
	} vfc_state_t;
endpackage : vfc_pkg

// ### rtl/vfc_ctrl.sv
// Purpose: control register, single-wire pulse bus slave, address and trim logic
// Assumes: open-drain data pin resolved outside; rc and trim comparators are async
// Notes:   on-wire frame layout is documented in the hand-over
// Notes on behaviour
// - One 8-bit control register, host-written, drives all channel controls.
// - Sync direction 0 makes sync pin output, 1 makes it input.
// - Input select 0 routes input B, 1 routes input A.
// - Bypass field 1 keeps filter in path, 0 bypasses it.
// - Two-bit boost picks none, 0.45dB, 0.90dB or 1.35dB.
// - Output disable mutes the channel for wired-OR multiplexing.
// - Output disable 0 normal output, 1 high impedance.
// - Clamp field 0 selects 1V, 1 selects 1.5V.
// - Up to 16 devices share the bus, each with its 4-bit address.
// - Host addresses one device or broadcasts to all.
// - Active-low bus, three pulse widths: one, zero, command.
// - Data pin carries transfers both ways.
// - Address derived from external RC time constant.
// - Corner frequency trimmed continuously regardless of register.
`timescale 1ns/1ps
`include "vfc_defines.svh"

module vfc_ctrl #(
	parameter int unsigned T1_MIN_CYC   = (`VFC_T1_MIN_NS + `VFC_CLK_NS - 1) / `VFC_CLK_NS,
	parameter int unsigned T1_MAX_CYC   = `VFC_T1_MAX_NS / `VFC_CLK_NS,
	parameter int unsigned TT_MIN_CYC   = (`VFC_TT_MIN_NS + `VFC_CLK_NS - 1) / `VFC_CLK_NS,
	parameter int unsigned TT_MAX_CYC   = `VFC_TT_MAX_NS / `VFC_CLK_NS,
	parameter int unsigned ADDR_STEP_CYC = `VFC_ADDR_STEP_NS / `VFC_CLK_NS
) (
	input  wire logic       clk_sys_in,
	input  wire logic       sys_rst_in,
	input  wire logic       data_in,
	output logic            data_out_out,
	output logic            data_oe_out,
	input  wire logic       bias_resistor_pin_in,
	input  wire logic       trim_fast_in,
	output logic [5:0]      trim_code_out,
	output logic            sync_pin_dir_out,
	output logic            sync_oe_out,
	output logic            input_select_out,
	output logic            filter_in_path_out,
	output logic            clamp_level_sel_out,
	output logic [1:0]      hf_gain_out,
	output logic            output_mute_out,
	output logic            output_oe_out,
	output logic [3:0]      bus_addr_out,
	output logic            bus_addr_valid_out
);
	localparam int unsigned T0_MIN_CYC   = (`VFC_T0_MIN_NS + `VFC_CLK_NS - 1) / `VFC_CLK_NS;
	localparam int unsigned T0_MAX_CYC   = `VFC_T0_MAX_NS / `VFC_CLK_NS;
	localparam int unsigned READ_LOW_CYC = `VFC_READ_LOW_NS / `VFC_CLK_NS;
	localparam int unsigned TRIM_CYC     = `VFC_TRIM_NS / `VFC_CLK_NS;

	// Synchronisers; stage one is read only by stage two
	logic [2:0]             sy1_r;
	logic [2:0]             sy2_r;
	logic                   line_d_r;
	logic                   line_s;
	logic                   rc_s;
	logic                   fast_s;

	// Idle levels; a high comparator here would freeze the address at zero
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sy1_r    <= 3'h1;
			sy2_r    <= 3'h1;
			line_d_r <= 1'b1;
		end else begin
			sy1_r    <= {trim_fast_in, bias_resistor_pin_in, data_in};
			sy2_r    <= sy1_r;
			line_d_r <= sy2_r[0];
		end
	end
	assign line_s = sy2_r[0];
	assign rc_s   = sy2_r[1];
	assign fast_s = sy2_r[2];

	// Pulse width measurement
	vfc_pkg::vfc_state_t    st_r;
	vfc_pkg::vfc_state_t    st_nxt;
	vfc_pkg::vfc_pulse_t    pk;
	logic [14:0]            low_cnt_r;
	logic [14:0]            low_cnt_nxt;
	logic                   own_drive;

	assign own_drive = (st_r == vfc_pkg::ST_RDRV) || (st_r == vfc_pkg::ST_RGAP);

	always_comb begin
		low_cnt_nxt = 15'h0;
		if (!line_s && !own_drive && low_cnt_r != `VFC_LOW_SAT) begin
			low_cnt_nxt = low_cnt_r + 15'h1;
		end else if (!line_s && !own_drive) begin
			low_cnt_nxt = low_cnt_r;
		end
		pk = vfc_pkg::PK_NONE;
		if (line_s && !line_d_r && !own_drive && low_cnt_r != 15'h0) begin
			// Widths between the bands are classed PK_BAD and send a frame in progress back to idle
			if (low_cnt_r >= T0_MIN_CYC && low_cnt_r <= T0_MAX_CYC) begin
				pk = vfc_pkg::PK_ZERO;
			end else if (low_cnt_r >= T1_MIN_CYC && low_cnt_r <= T1_MAX_CYC) begin
				pk = vfc_pkg::PK_ONE;
			end else if (low_cnt_r >= TT_MIN_CYC && low_cnt_r <= TT_MAX_CYC) begin
				pk = vfc_pkg::PK_TRANS;
			end else begin
				pk = vfc_pkg::PK_BAD;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			low_cnt_r <= 15'h0;
		end else begin
			low_cnt_r <= low_cnt_nxt;
		end
	end

	// Address from RC charge time after reset
	logic [21:0]            step_cnt_r;
	logic [21:0]            step_cnt_nxt;
	logic [3:0]             addr_r;
	logic [3:0]             addr_nxt;
	logic                   addr_valid_r;
	logic                   addr_valid_nxt;

	always_comb begin
		step_cnt_nxt   = step_cnt_r;
		addr_nxt       = addr_r;
		addr_valid_nxt = addr_valid_r;
		if (!addr_valid_r) begin
			if (rc_s || addr_r == `VFC_ADDR_MAX) begin
				addr_valid_nxt = 1'b1;
			end else if (step_cnt_r == 22'(ADDR_STEP_CYC - 1)) begin
				step_cnt_nxt = 22'h0;
				addr_nxt     = addr_r + 4'h1;
			end else begin
				step_cnt_nxt = step_cnt_r + 22'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			step_cnt_r   <= 22'h0;
			addr_r       <= 4'h0;
			addr_valid_r <= 1'b0;
		end else begin
			step_cnt_r   <= step_cnt_nxt;
			addr_r       <= addr_nxt;
			addr_valid_r <= addr_valid_nxt;
		end
	end

	// Frame engine
	vfc_pkg::vfc_ctrl_t     ctrl_r;
	vfc_pkg::vfc_ctrl_t     ctrl_nxt;
	logic [1:0]             cmd_r;
	logic [1:0]             cmd_nxt;
	logic [3:0]             adr_sh_r;
	logic [3:0]             adr_sh_nxt;
	logic [7:0]             dat_r;
	logic [7:0]             dat_nxt;
	logic [2:0]             bit_r;
	logic [2:0]             bit_nxt;
	logic                   bcast_r;
	logic                   bcast_nxt;
	logic [10:0]            drv_cnt_r;
	logic [10:0]            drv_cnt_nxt;
	logic                   bit_pk;
	logic                   bit_val;
	logic                   match;
	logic                   commit;

	assign bit_pk  = (pk == vfc_pkg::PK_ZERO) || (pk == vfc_pkg::PK_ONE);
	assign bit_val = (pk == vfc_pkg::PK_ONE);
	assign match   = addr_valid_r && (adr_sh_nxt == addr_r);
	assign commit  = (st_r == vfc_pkg::ST_END) && (pk == vfc_pkg::PK_TRANS);

	always_comb begin
		st_nxt      = st_r;
		cmd_nxt     = cmd_r;
		adr_sh_nxt  = adr_sh_r;
		dat_nxt     = dat_r;
		bit_nxt     = bit_r;
		bcast_nxt   = bcast_r;
		drv_cnt_nxt = drv_cnt_r;
		ctrl_nxt    = ctrl_r;
		unique case (st_r)
			vfc_pkg::ST_IDLE: begin
				bit_nxt = 3'h0;
				if (pk == vfc_pkg::PK_TRANS) begin
					st_nxt = vfc_pkg::ST_CMD;
				end
			end
			vfc_pkg::ST_CMD: begin
				if (bit_pk) begin
					cmd_nxt = {bit_val, cmd_r[1]};
					bit_nxt = bit_r + 3'h1;
					if (bit_r == 3'h1) begin
						bit_nxt   = 3'h0;
						bcast_nxt = (cmd_nxt == `VFC_CMD_BCAST);
						if (cmd_nxt == `VFC_CMD_BCAST) begin
							st_nxt = vfc_pkg::ST_DATA;
						end else if (cmd_nxt == `VFC_CMD_WRITE || cmd_nxt == `VFC_CMD_READ) begin
							st_nxt = vfc_pkg::ST_ADDR;
						end else begin
							st_nxt = vfc_pkg::ST_IDLE;
						end
					end
				end
			end
			vfc_pkg::ST_ADDR: begin
				if (bit_pk) begin
					adr_sh_nxt = {bit_val, adr_sh_r[3:1]};
					bit_nxt    = bit_r + 3'h1;
					if (bit_r == 3'h3) begin
						bit_nxt = 3'h0;
						if (cmd_r != `VFC_CMD_READ) begin
							st_nxt = vfc_pkg::ST_DATA;
						end else if (match) begin
							st_nxt  = vfc_pkg::ST_READ;
							dat_nxt = ctrl_r;
						end else begin
							st_nxt = vfc_pkg::ST_IDLE;
						end
					end
				end
			end
			vfc_pkg::ST_DATA: begin
				if (bit_pk) begin
					dat_nxt = {bit_val, dat_r[7:1]};
					bit_nxt = bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						st_nxt = vfc_pkg::ST_END;
					end
				end
			end
			vfc_pkg::ST_END: begin
				if (pk != vfc_pkg::PK_NONE) begin
					st_nxt = vfc_pkg::ST_IDLE;
				end
				// Foreign or partial frames never reach here with a match
				if (commit && (bcast_r || (addr_valid_r && adr_sh_r == addr_r))) begin
					ctrl_nxt      = dat_r;
					ctrl_nxt.rsvd = 1'b0;
				end
			end
			vfc_pkg::ST_READ: begin
				if (pk == vfc_pkg::PK_ZERO) begin
					dat_nxt = {1'b0, dat_r[7:1]};
					bit_nxt = bit_r + 3'h1;
					if (!dat_r[0]) begin
						st_nxt      = vfc_pkg::ST_RDRV;
						drv_cnt_nxt = 11'h0;
					end else if (bit_r == 3'h7) begin
						st_nxt = vfc_pkg::ST_IDLE;
					end
				end
			end
			vfc_pkg::ST_RDRV: begin
				drv_cnt_nxt = drv_cnt_r + 11'h1;
				if (drv_cnt_r == 11'(READ_LOW_CYC - 1)) begin
					st_nxt = vfc_pkg::ST_RGAP;
				end
			end
			vfc_pkg::ST_RGAP: begin
				// Wait for our own low to clear the synchroniser
				if (line_s && line_d_r) begin
					st_nxt = (bit_r == 3'h0) ? vfc_pkg::ST_IDLE : vfc_pkg::ST_READ;
				end
			end
		endcase
		if (!own_drive && st_r != vfc_pkg::ST_IDLE && st_r != vfc_pkg::ST_END) begin
			if (pk == vfc_pkg::PK_TRANS) begin
				st_nxt  = vfc_pkg::ST_CMD;
				bit_nxt = 3'h0;
			end else if (pk == vfc_pkg::PK_BAD) begin
				st_nxt = vfc_pkg::ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			st_r      <= vfc_pkg::ST_IDLE;
			cmd_r     <= 2'h0;
			adr_sh_r  <= 4'h0;
			dat_r     <= 8'h00;
			bit_r     <= 3'h0;
			bcast_r   <= 1'b0;
			drv_cnt_r <= 11'h0;
			ctrl_r    <= `VFC_CTRL_RESET;
		end else begin
			st_r      <= st_nxt;
			cmd_r     <= cmd_nxt;
			adr_sh_r  <= adr_sh_nxt;
			dat_r     <= dat_nxt;
			bit_r     <= bit_nxt;
			bcast_r   <= bcast_nxt;
			drv_cnt_r <= drv_cnt_nxt;
			ctrl_r    <= ctrl_nxt;
		end
	end

	// Continuous corner trim, independent of the register
	logic [7:0]             trim_cnt_r;
	logic [7:0]             trim_cnt_nxt;
	logic [5:0]             trim_r;
	logic [5:0]             trim_nxt;
	logic                   trim_tick;

	assign trim_tick = (trim_cnt_r == 8'(TRIM_CYC - 1));

	always_comb begin
		trim_cnt_nxt = trim_tick ? 8'h0 : trim_cnt_r + 8'h1;
		trim_nxt     = trim_r;
		if (trim_tick && fast_s && trim_r != 6'h0) begin
			trim_nxt = trim_r - 6'h1;
		end else if (trim_tick && !fast_s && trim_r != `VFC_TRIM_TOP) begin
			trim_nxt = trim_r + 6'h1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			trim_cnt_r <= 8'h0;
			trim_r     <= `VFC_TRIM_MID;
		end else begin
			trim_cnt_r <= trim_cnt_nxt;
			trim_r     <= trim_nxt;
		end
	end

	// Pin and control outputs, all decoded from flip-flops except data_out_out, which is tied low
	assign data_out_out        = 1'b0;
	assign data_oe_out         = (st_r == vfc_pkg::ST_RDRV);
	assign trim_code_out       = trim_r;
	assign sync_pin_dir_out    = ctrl_r.sync_pin_dir;
	assign sync_oe_out         = !ctrl_r.sync_pin_dir;
	assign input_select_out    = ctrl_r.input_select;
	assign filter_in_path_out  = ctrl_r.filter_in_path;
	assign clamp_level_sel_out = ctrl_r.clamp_level_sel;
	assign hf_gain_out         = {ctrl_r.hf_gain_hi, ctrl_r.hf_gain_lo};
	assign output_mute_out     = ctrl_r.output_mute;
	assign output_oe_out       = !ctrl_r.output_mute;
	assign bus_addr_out        = addr_r;
	assign bus_addr_valid_out  = addr_valid_r;

	AST_RESET_VAL: assert property (@(posedge clk_sys_in)
		sys_rst_in |=> (ctrl_r == `VFC_CTRL_RESET)) else $error("bad reset value");
	AST_HOLD: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		!commit |=> $stable(ctrl_r)) else $error("register changed without frame");
	AST_COMMIT_SRC: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(ctrl_nxt != ctrl_r) |-> (bcast_r || (addr_valid_r && adr_sh_r == addr_r)))
		else $error("foreign write");
	AST_DIR_PINS: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(sync_oe_out != sync_pin_dir_out) && (output_oe_out != output_mute_out))
		else $error("pin direction mismatch");
	AST_ONE_BAND: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(pk == vfc_pkg::PK_ONE) |-> (low_cnt_r >= T1_MIN_CYC && low_cnt_r <= T1_MAX_CYC))
		else $error("one pulse out of band");
	AST_DRV_LEN: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		$fell(data_oe_out) |-> ($past(drv_cnt_r) == 11'(READ_LOW_CYC - 1)))
		else $error("read drive length wrong");
	AST_DRV_SRC: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		$rose(data_oe_out) |-> ($past(st_r) == vfc_pkg::ST_READ && $past(pk) == vfc_pkg::PK_ZERO))
		else $error("drive without prompt");
	AST_ADDR_HOLD: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		addr_valid_r |=> ($stable(addr_r) && addr_valid_r)) else $error("address moved");
	AST_TRIM_STEP: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(trim_tick && !fast_s && trim_r != `VFC_TRIM_TOP) |=> (trim_r == $past(trim_r) + 6'h1))
		else $error("trim did not step");

	COV_UNICAST: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		commit && !bcast_r && adr_sh_r == addr_r);
	COV_BCAST: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		commit && bcast_r);
	COV_READ: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		$rose(data_oe_out));
	COV_BAD: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		pk == vfc_pkg::PK_BAD);
endmodule : vfc_ctrl

// ### bench/vfc_host_model.sv
// Purpose: host side of the single-wire pulse bus, drives frames and reads back
// Assumes: wire resolved by the bench with a pull-up, host pulls low only
// Notes:   pulse widths are parameters so the bench can shorten long counts
`timescale 1ns/1ps
`include "vfc_defines.svh"

module vfc_host_model #(
	parameter int ZERO_CYC    = 255,
	parameter int ONE_CYC     = 2010,
	parameter int TRANS_CYC   = 2120,
	parameter int GAP_CYC     = 125,
	parameter int SAMPLE_CYC  = 800,
	parameter int RECLAIM_CYC = 3260
) (
	input  wire logic clk_sys_in,
	input  wire logic wire_in,
	output logic      host_low_out
);
	initial host_low_out = 1'b0;

	// Active-low pulse, then the idle gap
	task automatic pulse(input int n);
		@(posedge clk_sys_in);
		#1 host_low_out = 1'b1;
		repeat (n) @(posedge clk_sys_in);
		#1 host_low_out = 1'b0;
		repeat (GAP_CYC) @(posedge clk_sys_in);
	endtask : pulse

	task automatic send_bit(input logic b);
		pulse(b ? ONE_CYC : ZERO_CYC);
	endtask : send_bit

	// Unicast or broadcast write, fields LSB first
	task automatic wr(input logic [1:0] cmd, input logic [3:0] addr, input logic [7:0] data);
		pulse(TRANS_CYC);
		for (int i = 0; i < 2; i++) send_bit(cmd[i]);
		if (cmd != `VFC_CMD_BCAST) begin
			for (int i = 0; i < 4; i++) send_bit(addr[i]);
		end
		for (int i = 0; i < 8; i++) send_bit(data[i]);
		pulse(TRANS_CYC);
	endtask : wr

	// Read: released wire sampled mid-window, reclaim respected before next prompt
	task automatic rd(input logic [3:0] addr, output logic [7:0] data);
		logic [1:0] cmd;
		cmd = `VFC_CMD_READ;
		pulse(TRANS_CYC);
		for (int i = 0; i < 2; i++) send_bit(cmd[i]);
		for (int i = 0; i < 4; i++) send_bit(addr[i]);
		for (int i = 0; i < 8; i++) begin
			pulse(ZERO_CYC);
			repeat (SAMPLE_CYC - GAP_CYC) @(posedge clk_sys_in);
			data[i] = wire_in;
			repeat (RECLAIM_CYC - SAMPLE_CYC) @(posedge clk_sys_in);
		end
	endtask : rd
endmodule : vfc_host_model

// ### bench/tb_video_filter_control_register.sv
// Purpose: self-checking bench of the control register and its pulse bus
// Assumes: pulse windows scaled down, zero pulse kept in its fixed window
// Notes:   trim checked loosely since its step phase is free running
`timescale 1ns/1ps
`include "vfc_defines.svh"

module tb_video_filter_control_register;
	// Same as the host model's transaction width
	localparam int TRANS = 2120;
	logic        clk_sys_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        bias_resistor_pin_in = 1'b0;
	logic        trim_fast_in = 1'b0;
	logic        data_out_out, data_oe_out, host_low;
	logic        sync_pin_dir_out, sync_oe_out, input_select_out, filter_in_path_out;
	logic        clamp_level_sel_out, output_mute_out, output_oe_out, bus_addr_valid_out;
	logic [1:0]  hf_gain_out;
	logic [3:0]  bus_addr_out;
	logic [5:0]  trim_code_out;
	logic [7:0]  obs_ctrl, rdv;
	wire logic   data_wire;
	int          n_errors = 0;
	int          n_tests = 0;

	always #2 clk_sys_in = ~clk_sys_in;
	// Pull-up: released wire reads high
	assign data_wire = ~(host_low | (data_oe_out & ~data_out_out));
	assign obs_ctrl = {sync_pin_dir_out, input_select_out, filter_in_path_out,
		clamp_level_sel_out, hf_gain_out, output_mute_out, 1'b0};

	vfc_ctrl #(.T1_MIN_CYC(2005), .T1_MAX_CYC(2060), .TT_MIN_CYC(2080), .TT_MAX_CYC(2200),
		.ADDR_STEP_CYC(20)) dut_u (
		.clk_sys_in          (clk_sys_in),
		.sys_rst_in          (sys_rst_in),
		.data_in             (data_wire),
		.data_out_out        (data_out_out),
		.data_oe_out         (data_oe_out),
		.bias_resistor_pin_in(bias_resistor_pin_in),
		.trim_fast_in        (trim_fast_in),
		.trim_code_out       (trim_code_out),
		.sync_pin_dir_out    (sync_pin_dir_out),
		.sync_oe_out         (sync_oe_out),
		.input_select_out    (input_select_out),
		.filter_in_path_out  (filter_in_path_out),
		.clamp_level_sel_out (clamp_level_sel_out),
		.hf_gain_out         (hf_gain_out),
		.output_mute_out     (output_mute_out),
		.output_oe_out       (output_oe_out),
		.bus_addr_out        (bus_addr_out),
		.bus_addr_valid_out  (bus_addr_valid_out)
	);

	vfc_host_model host_u (
		.clk_sys_in  (clk_sys_in),
		.wire_in     (data_wire),
		.host_low_out(host_low)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Fields plus the two enables that follow them
	task automatic check_ctrl(input logic [7:0] exp);
		check(obs_ctrl, exp);
		check({7'h0, sync_oe_out}, {7'h0, ~exp[7]});
		check({7'h0, output_oe_out}, {7'h0, ~exp[1]});
	endtask : check_ctrl

	task automatic tally_and_finish;
		$display("counts: tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog, all bus waits are fixed counts
	initial begin
		repeat (106000) @(posedge clk_sys_in);
		n_errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge clk_sys_in);
		#1 sys_rst_in = 1'b0;
		check_ctrl(`VFC_CTRL_RESET);
		check({2'h0, trim_code_out}, {2'h0, `VFC_TRIM_MID});
		check({2'h0, bus_addr_valid_out, bus_addr_out, data_oe_out}, 8'h00);
		$display("test reset done");
		// RC input rises midway through the third step
		repeat (50) @(posedge clk_sys_in);
		#1 bias_resistor_pin_in = 1'b1;
		repeat (10) @(posedge clk_sys_in);
		check({3'h0, bus_addr_valid_out, bus_addr_out}, 8'h12);
		$display("test address done");
		host_u.wr(`VFC_CMD_WRITE, 4'h2, 8'h9a);
		check_ctrl(8'h9a);
		host_u.wr(`VFC_CMD_WRITE, 4'h0, 8'h00);
		check_ctrl(8'h9a);
		host_u.wr(`VFC_CMD_BCAST, 4'h0, 8'h64);
		check_ctrl(8'h64);
		$display("test writes done");
		// Broadcast cut short by a new transaction pulse
		host_u.pulse(TRANS);
		host_u.send_bit(1'b0);
		host_u.send_bit(1'b1);
		host_u.send_bit(1'b0);
		host_u.send_bit(1'b0);
		check_ctrl(8'h64);
		host_u.wr(`VFC_CMD_BCAST, 4'h0, 8'h2c);
		check_ctrl(8'h2c);
		$display("test restart done");
		host_u.rd(4'h2, rdv);
		check(rdv, 8'h2c);
		check({7'h0, data_oe_out}, 8'h00);
		$display("test read done");
		check({2'h0, trim_code_out}, {2'h0, `VFC_TRIM_TOP});
		@(posedge clk_sys_in);
		#1 trim_fast_in = 1'b1;
		repeat (1000) @(posedge clk_sys_in);
		check({7'h0, trim_code_out >= 6'h3a && trim_code_out <= 6'h3c}, 8'h01);
		$display("test trim done");
		tally_and_finish();
	end
endmodule : tb_video_filter_control_register
